// file: hdl/sfspi_pkg.sv
// shared constants and types of the serial flash front end
package sfspi_pkg;
    // memory organisation
    localparam int sector_count = 128;
    localparam int pages_per_sector = 256;
    localparam int bytes_per_page = 256;
    localparam int sector_w = 7;
    localparam int page_w = 8;
    localparam int byte_w = 8;
    localparam int addr_w = sector_w + page_w + byte_w;
    localparam int cmd_w = 8;
    localparam int addr_bytes = 3;
    localparam int max_program_bytes = 256;
    localparam int min_program_bytes = 1;
    // serial byte bit counter
    localparam logic [2:0] last_bit = 3'h7;
    // instruction codes
    localparam logic [7:0] op_write_enable = 8'h06;
    localparam logic [7:0] op_read = 8'h03;
    localparam logic [7:0] op_page_program = 8'h02;
    localparam logic [7:0] op_sector_erase = 8'hd8;
    localparam logic [7:0] op_bulk_erase = 8'hc7;
    // internal busy cycles, normal and accelerated
    localparam int busy_w = 16;
    localparam logic [15:0] program_cycles = 16'h0400;
    localparam logic [15:0] program_cycles_fast = 16'h0100;
    localparam logic [15:0] sector_erase_cycles = 16'h1000;
    localparam logic [15:0] sector_erase_cycles_fast = 16'h0800;
    localparam logic [15:0] bulk_erase_cycles = 16'hf000;
    localparam logic [15:0] bulk_erase_cycles_fast = 16'h8000;
    // reset values
    localparam logic [2:0] protect_reset = 3'h0;
    localparam logic [23:0] addr_reset = 24'h000000;

    typedef enum logic [2:0] {
        sfspi_st_cmd = 3'b000,
        sfspi_st_addr = 3'b001,
        sfspi_st_read = 3'b010,
        sfspi_st_prog = 3'b011,
        sfspi_st_ignore = 3'b100
    } sfspi_state_t;

    typedef enum logic [1:0] {
        sfspi_op_none = 2'b00,
        sfspi_op_program = 2'b01,
        sfspi_op_sector = 2'b10,
        sfspi_op_bulk = 2'b11
    } sfspi_op_t;
endpackage

// file: hdl/sfspi_edge_if.sv
// sampled link pins and the edge strobes found on them
`timescale 1ns/10ps
`default_nettype none
interface sfspi_edge_if;
    logic sclk_rise;
    logic sclk_fall;
    logic sel;
    logic sel_fall;
    logic mosi;
    logic hold_n;
    modport src(output sclk_rise, sclk_fall, sel, sel_fall, mosi, hold_n);
    modport dst(input sclk_rise, sclk_fall, sel, sel_fall, mosi, hold_n);
endinterface
`default_nettype wire

// file: hdl/sfspi_pin_sync.sv
// synchronises link pins and derives clock and select edges
`timescale 1ns/10ps
`default_nettype none
module sfspi_pin_sync (
    // system
    input wire logic clk,
    input wire logic rst,
    // raw pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic hold_n,
    // sampled pins
    sfspi_edge_if.src edges
);
    logic [3:0] meta;
    logic [3:0] sync;
    logic sclk_d;
    logic sel_d;
    logic [1:0] warm;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // reset to the idle pin levels so no false edge follows
            meta <= 4'ha;
            sync <= 4'ha;
        end else begin
            meta <= {hold_n, mosi, cs_n, sclk};
            sync <= meta;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_d <= 1'b0;
            sel_d <= 1'b1;
            warm <= 2'h0;
        end else begin
            sclk_d <= sync[0];
            // a select already low at reset release is not a falling edge
            sel_d <= warm[1] ? ~sync[1] : 1'b1;
            warm <= {warm[0], 1'b1};
        end
    end

    assign edges.sclk_rise = sync[0] & ~sclk_d;
    assign edges.sclk_fall = ~sync[0] & sclk_d;
    assign edges.sel = ~sync[1];
    assign edges.sel_fall = ~sync[1] & ~sel_d;
    assign edges.mosi = sync[2];
    assign edges.hold_n = sync[3];
endmodule
`default_nettype wire

// file: hdl/sfspi_busy_timer.sv
// internal program and erase cycle timer
`timescale 1ns/10ps
`default_nettype none
module sfspi_busy_timer (
    // system
    input wire logic clk,
    input wire logic rst,
    // start request
    input wire logic start,
    input wire logic [15:0] cycles,
    // status
    output logic busy,
    output logic done
);
    logic [15:0] count;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 16'h0000;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                count <= cycles;
                busy <= 1'b1;
            end else if (busy) begin
                if (count == 16'h0000) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - 16'h0001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: hdl/sfspi_front_end.sv
// serial flash front end: pins, shifting, hold, memory, program/erase
//
// Summary of operation
// - output bits shift out on falling clock
// - input bits sampled on rising clock
// - deselected means output high impedance
// - standby when deselected and not busy
// - select low gives active power mode
// - ignore activity until first select fall
// - hold pauses transfer keeping its state
// - in hold, output off, inputs ignored
// - hold only entered while selected
// - 128 sectors, 256 pages, 256 bytes; the array image holds one page only
// - page program takes 1 to 256 bytes
// - sector erase or whole array erase
// - elevated pin level selects fast mode
// - logic-level protect pin locks protect bits
`timescale 1ns/10ps
`default_nettype none
module sfspi_front_end (
    // system
    input wire logic clk,
    input wire logic rst,
    // serial link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic hold_n,
    output logic miso_o,
    output logic miso_oe,
    // write protect pin: logic level and elevated supply detect
    input wire logic write_protect_n,
    input wire logic elevated_program_level,
    // protection configuration
    input wire logic [2:0] block_protect_bits,
    // status
    output logic active_power,
    output logic write_busy,
    output logic fast_mode,
    output logic [2:0] protect_locked
);
    sfspi_edge_if edges ();

    sfspi_pin_sync u_sync (
        .clk(clk),
        .rst(rst),
        .sclk(sclk),
        .cs_n(cs_n),
        .mosi(mosi),
        .hold_n(hold_n),
        .edges(edges)
    );

    logic [7:0] mem [0:255];
    logic [7:0] page_buf [0:255];

    sfspi_pkg::sfspi_state_t state;
    logic armed;
    logic hold;
    logic [2:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic [7:0] opcode;
    logic [1:0] addr_cnt;
    logic [23:0] addr;
    logic [8:0] prog_count;
    logic write_enabled;
    logic wp_meta;
    logic wp_sync;
    logic hv_meta;
    logic hv_sync;
    sfspi_pkg::sfspi_op_t pend_op;
    logic busy_start;
    logic [15:0] busy_cycles;
    logic busy;
    logic busy_done;
    sfspi_pkg::sfspi_op_t run_op;
    logic buf_clear;
    logic buf_load;

    logic live;
    logic rise_ok;
    logic fall_ok;
    logic [7:0] byte_in;
    logic [7:0] byte_idx;

    sfspi_busy_timer u_timer (
        .clk(clk),
        .rst(rst),
        .start(busy_start),
        .cycles(busy_cycles),
        .busy(busy),
        .done(busy_done)
    );

    // the array image holds one page, so only the byte index selects
    assign byte_idx = addr[7:0];

    assign live = armed && edges.sel && !hold;
    assign rise_ok = live && edges.sclk_rise;
    assign fall_ok = live && edges.sclk_fall;
    assign byte_in = {shift_in[6:0], edges.mosi};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_meta <= 1'b0;
            wp_sync <= 1'b0;
            hv_meta <= 1'b0;
            hv_sync <= 1'b0;
        end else begin
            wp_meta <= write_protect_n;
            wp_sync <= wp_meta;
            hv_meta <= elevated_program_level;
            hv_sync <= hv_meta;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed <= 1'b0;
        end else if (edges.sel_fall) begin
            armed <= 1'b1;
        end
    end

    // hold pauses only a selected device and leaves shift state intact
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold <= 1'b0;
        end else if (!edges.sel) begin
            hold <= 1'b0;
        end else if (!edges.hold_n && !edges.sclk_rise) begin
            hold <= 1'b1;
        end else if (edges.hold_n && !edges.sclk_rise) begin
            hold <= 1'b0;
        end
    end

    // serial instruction engine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= sfspi_pkg::sfspi_st_cmd;
            bit_cnt <= 3'h0;
            shift_in <= 8'h00;
            opcode <= 8'h00;
            addr_cnt <= 2'h0;
            addr <= sfspi_pkg::addr_reset;
            prog_count <= 9'h000;
            write_enabled <= 1'b0;
            pend_op <= sfspi_pkg::sfspi_op_none;
        end else if (!edges.sel) begin
            state <= sfspi_pkg::sfspi_st_cmd;
            bit_cnt <= 3'h0;
            addr_cnt <= 2'h0;
            if (opcode == sfspi_pkg::op_page_program && prog_count != 9'h000
                    && bit_cnt == 3'h0 && !busy) begin
                pend_op <= sfspi_pkg::sfspi_op_program;
                write_enabled <= 1'b0;
            end
            opcode <= 8'h00;
            prog_count <= 9'h000;
            if (busy_start) begin
                pend_op <= sfspi_pkg::sfspi_op_none;
            end
        end else if (rise_ok) begin
            shift_in <= byte_in;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == sfspi_pkg::last_bit) begin
                case (state)
                    sfspi_pkg::sfspi_st_cmd: begin
                        opcode <= byte_in;
                        state <= sfspi_pkg::sfspi_st_ignore;
                        if (byte_in == sfspi_pkg::op_write_enable) begin
                            write_enabled <= 1'b1;
                        end else if (byte_in == sfspi_pkg::op_bulk_erase
                                && write_enabled && !busy) begin
                            pend_op <= sfspi_pkg::sfspi_op_bulk;
                            write_enabled <= 1'b0;
                        end else if (byte_in == sfspi_pkg::op_read
                                || byte_in == sfspi_pkg::op_sector_erase
                                || (byte_in == sfspi_pkg::op_page_program
                                && write_enabled)) begin
                            state <= sfspi_pkg::sfspi_st_addr;
                        end
                    end
                    sfspi_pkg::sfspi_st_addr: begin
                        addr <= {addr[15:0], byte_in};
                        addr_cnt <= addr_cnt + 2'h1;
                        if (addr_cnt == 2'h2) begin
                            state <= sfspi_pkg::sfspi_st_ignore;
                            if (opcode == sfspi_pkg::op_read) begin
                                state <= sfspi_pkg::sfspi_st_read;
                            end else if (opcode == sfspi_pkg::op_page_program)
                                    begin
                                state <= sfspi_pkg::sfspi_st_prog;
                            end else if (write_enabled && !busy) begin
                                pend_op <= sfspi_pkg::sfspi_op_sector;
                                write_enabled <= 1'b0;
                            end
                        end
                    end
                    sfspi_pkg::sfspi_st_read: begin
                        addr <= addr + 24'h000001;
                    end
                    sfspi_pkg::sfspi_st_prog: begin
                        // wraps within the page; count saturates at 256
                        addr[7:0] <= addr[7:0] + 8'h01;
                        if (prog_count != 9'h100) begin
                            prog_count <= prog_count + 9'h001;
                        end
                    end
                    default: begin
                        state <= sfspi_pkg::sfspi_st_ignore;
                    end
                endcase
            end
        end else if (busy_start) begin
            pend_op <= sfspi_pkg::sfspi_op_none;
        end
    end

    // page buffer starts all ones so bytes not sent leave memory alone
    assign buf_clear = rise_ok && bit_cnt == sfspi_pkg::last_bit
        && state == sfspi_pkg::sfspi_st_addr && addr_cnt == 2'h2
        && opcode == sfspi_pkg::op_page_program;
    assign buf_load = rise_ok && bit_cnt == sfspi_pkg::last_bit
        && state == sfspi_pkg::sfspi_st_prog;

    // pending operation is cleared at start, so keep what is running
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_op <= sfspi_pkg::sfspi_op_none;
        end else if (busy_start) begin
            run_op <= pend_op;
        end
    end

    for (genvar g = 0; g < sfspi_pkg::bytes_per_page; g++) begin : g_cell
        always_ff @(posedge clk) begin
            if (buf_clear) begin
                page_buf[g] <= 8'hff;
            end else if (buf_load && byte_idx == 8'(g)) begin
                page_buf[g] <= byte_in;
            end
        end
        // programming only clears bits; either erase sets them all
        always_ff @(posedge clk) begin
            if (busy_done && run_op == sfspi_pkg::sfspi_op_program) begin
                mem[g] <= mem[g] & page_buf[g];
            end else if (busy_done
                    && run_op != sfspi_pkg::sfspi_op_none) begin
                mem[g] <= 8'hff;
            end
        end
    end

    always_comb begin
        busy_start = (pend_op != sfspi_pkg::sfspi_op_none) && !edges.sel
            && !busy;
        case (pend_op)
            sfspi_pkg::sfspi_op_program: busy_cycles = hv_sync
                ? sfspi_pkg::program_cycles_fast : sfspi_pkg::program_cycles;
            sfspi_pkg::sfspi_op_sector: busy_cycles = hv_sync
                ? sfspi_pkg::sector_erase_cycles_fast
                : sfspi_pkg::sector_erase_cycles;
            sfspi_pkg::sfspi_op_bulk: busy_cycles = hv_sync
                ? sfspi_pkg::bulk_erase_cycles_fast
                : sfspi_pkg::bulk_erase_cycles;
            default: busy_cycles = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_out <= 8'h00;
            miso_o <= 1'b0;
        end else if (fall_ok && state == sfspi_pkg::sfspi_st_read) begin
            if (bit_cnt == 3'h0) begin
                miso_o <= mem[byte_idx][7];
                shift_out <= {mem[byte_idx][6:0], 1'b0};
            end else begin
                miso_o <= shift_out[7];
                shift_out <= {shift_out[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            miso_oe <= 1'b0;
        end else begin
            miso_oe <= live && state == sfspi_pkg::sfspi_st_read;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active_power <= 1'b0;
            write_busy <= 1'b0;
            fast_mode <= 1'b0;
        end else begin
            active_power <= edges.sel || busy || busy_start;
            write_busy <= busy || busy_start;
            fast_mode <= hv_sync && (busy || busy_start);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            protect_locked <= sfspi_pkg::protect_reset;
        end else if (wp_sync && !hv_sync) begin
            protect_locked <= block_protect_bits;
        end
    end
endmodule
`default_nettype wire

// file: testbench/sfspi_front_end_props.sv
// port checker of the serial flash front end
`timescale 1ns/10ps
`default_nettype none
module sfspi_front_end_props (
    // system
    input wire logic clk,
    input wire logic rst,
    // link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic hold_n,
    input wire logic miso_o,
    input wire logic miso_oe,
    // protect pin
    input wire logic write_protect_n,
    input wire logic elevated_program_level,
    input wire logic [2:0] block_protect_bits,
    // status
    input wire logic active_power,
    input wire logic write_busy,
    input wire logic fast_mode,
    input wire logic [2:0] protect_locked
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic sclk_q;
    logic [3:0] since_fall;
    // cycles since the raw link clock last fell, saturating
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b0;
            since_fall <= 4'hf;
        end else begin
            sclk_q <= sclk;
            if (sclk_q && !sclk)
                since_fall <= 4'h0;
            else if (since_fall != 4'hf)
                since_fall <= since_fall + 4'h1;
        end
    end
    a_deselect_quiet:
        assert property (cs_n [*6] |-> !miso_oe)
        else $error("output driven while deselected");
    a_hold_quiet:
        assert property (!hold_n [*6] |-> !miso_oe)
        else $error("output driven during hold");
    a_hold_frozen:
        assert property (!hold_n [*8] |=> $stable(miso_o))
        else $error("output bit moved during hold");
    a_select_active:
        assert property (!cs_n [*6] |-> active_power)
        else $error("selected but not active");
    a_standby_idle:
        assert property ((cs_n && !write_busy) [*8] |-> !active_power)
        else $error("active while deselected and idle");
    a_protect_frozen:
        assert property (!write_protect_n [*4] |=> $stable(protect_locked))
        else $error("locked protect bits changed");
    a_shift_on_fall:
        assert property (($changed(miso_o) && miso_oe && $past(miso_oe))
            |-> since_fall <= 4'h8)
        else $error("output bit changed away from a falling edge");
    a_fast_level:
        assert property ($rose(write_busy)
            |=> fast_mode == elevated_program_level)
        else $error("fast mode does not follow the supply level");
    c_fast: cover property ($rose(write_busy) ##1 fast_mode);
    c_read: cover property ($rose(miso_oe));
    c_hold: cover property (!cs_n && !hold_n && $fell(miso_oe));
endmodule
bind sfspi_front_end sfspi_front_end_props u_props (
    .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .hold_n(hold_n), .miso_o(miso_o), .miso_oe(miso_oe),
    .write_protect_n(write_protect_n),
    .elevated_program_level(elevated_program_level),
    .block_protect_bits(block_protect_bits),
    .active_power(active_power), .write_busy(write_busy),
    .fast_mode(fast_mode), .protect_locked(protect_locked)
);
`default_nettype wire

// file: testbench/sfspi_master_model.sv
// mode 0 bus master model driving the link pins
`timescale 1ns/10ps
`default_nettype none
module sfspi_master_model (
    // system
    input wire logic clk,
    // link
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    output logic hold_n,
    input wire logic miso_o
);
    localparam realtime half = 24.0;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
        hold_n = 1'b1;
    end
    // offset keeps link edges away from the system clock edge
    task automatic select();
        @(posedge clk);
        #1.7 cs_n = 1'b0;
        #(half);
    endtask
    task automatic bit_xfer(input logic b, output logic r);
        mosi = b;
        #(half) sclk = 1'b1;
        r = miso_o;
        #(half) sclk = 1'b0;
    endtask
    task automatic byte_xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
            bit_xfer(tx[i], rx[i]);
    endtask
    // select already low when reset ends: no falling edge is seen
    task automatic early_select();
        cs_n = 1'b0;
    endtask
    task automatic deselect();
        #(half) cs_n = 1'b1;
        // released data line must not keep its last value
        mosi = ~mosi;
        #(half);
    endtask
    task automatic hold(input logic on);
        if (!cs_n)
            hold_n = !on;
        #(half);
    endtask
endmodule
`default_nettype wire

// file: testbench/test_serial_flash_spi_front_end.sv
// self-checking bench of the serial flash front end
`timescale 1ns/10ps
`default_nettype none
module test_serial_flash_spi_front_end;
    typedef struct {
        logic [23:0] addr;
        logic [7:0] data;
        logic fast;
    } sfspi_row_t;
    logic clk = 1'b0;
    logic rst, sclk, cs_n, mosi, hold_n, miso_o, miso_oe;
    logic write_protect_n, elevated_program_level;
    logic [2:0] block_protect_bits, protect_locked;
    logic active_power, write_busy, fast_mode;
    int num_errors = 0;
    int cmp_count = 0;
    sfspi_row_t rows [4] = '{'{24'h7fffff, 8'h5a, 1'b1},
        '{24'h000000, 8'ha5, 1'b0}, '{24'h010203, 8'h3c, 1'b1},
        '{24'h40807e, 8'h00, 1'b0}};
    always #2 clk = ~clk;
    sfspi_master_model m (.clk(clk), .sclk(sclk), .cs_n(cs_n),
        .mosi(mosi), .hold_n(hold_n), .miso_o(miso_o));
    sfspi_front_end dut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
        .mosi(mosi), .hold_n(hold_n), .miso_o(miso_o), .miso_oe(miso_oe),
        .write_protect_n(write_protect_n),
        .elevated_program_level(elevated_program_level),
        .block_protect_bits(block_protect_bits),
        .active_power(active_power), .write_busy(write_busy),
        .fast_mode(fast_mode), .protect_locked(protect_locked));
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic send(input logic [7:0] b);
        logic [7:0] r;
        m.byte_xfer(b, r);
    endtask
    task automatic start_cmd(input logic [7:0] op, input logic [23:0] a);
        m.select();
        send(op);
        for (int i = 2; i >= 0; i--)
            send(a[8*i +: 8]);
    endtask
    task automatic wren();
        m.select();
        send(sfspi_pkg::op_write_enable);
        m.deselect();
    endtask
    // timer starts only once the deselect has crossed the synchroniser
    task automatic wait_idle();
        int n = 0;
        repeat (8) @(negedge clk);
        while (write_busy !== 1'b0 && n < 70000) begin
            @(negedge clk);
            n++;
        end
        if (n == 70000) begin
            num_errors++;
            results();
        end
        repeat (8) @(negedge clk);
        check(active_power, 1'b0);
    endtask
    task automatic prog(input logic [23:0] a, input logic [7:0] d);
        wren();
        start_cmd(sfspi_pkg::op_page_program, a);
        send(d);
        m.deselect();
        repeat (8) @(negedge clk);
        check(write_busy, 1'b1);
        check(fast_mode, elevated_program_level);
        wait_idle();
    endtask
    task automatic read(input logic [23:0] a, input int hold_at,
                        output logic [7:0] r);
        logic g;
        start_cmd(sfspi_pkg::op_read, a);
        check(active_power, 1'b1);
        for (int i = 7; i >= 0; i--) begin
            if (i == hold_at) begin
                m.hold(1'b1);
                repeat (8) @(negedge clk);
                check(miso_oe, 1'b0);
                m.bit_xfer(1'b1, g);
                m.bit_xfer(1'b0, g);
                m.hold(1'b0);
            end
            m.bit_xfer(1'b0, r[i]);
        end
        m.deselect();
        repeat (8) @(negedge clk);
        check(miso_oe, 1'b0);
    endtask
    task automatic erase(input logic [7:0] op, input logic [23:0] a);
        wren();
        start_cmd(op, a);
        m.deselect();
        repeat (8) @(negedge clk);
        check(write_busy, 1'b1);
        wait_idle();
    endtask
    initial begin
        logic [7:0] r;
        rst = 1'b1;
        write_protect_n = 1'b1;
        elevated_program_level = 1'b0;
        block_protect_bits = 3'h5;
        repeat (4) @(negedge clk);
        m.early_select();
        check(active_power, 1'b0);
        check(miso_oe, 1'b0);
        @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(negedge clk);
        check(protect_locked, 3'h5);
        // a read with no select fall since reset must stay silent
        send(sfspi_pkg::op_read);
        repeat (3) send(8'h00);
        check(miso_oe, 1'b0);
        m.deselect();
        $display("test first select done");
        @(posedge clk);
        write_protect_n <= 1'b0;
        repeat (8) @(negedge clk);
        @(posedge clk);
        block_protect_bits <= 3'h2;
        repeat (8) @(negedge clk);
        check(protect_locked, 3'h5);
        $display("test protect done");
        @(posedge clk);
        elevated_program_level <= 1'b1;
        erase(sfspi_pkg::op_bulk_erase, 24'h000000);
        foreach (rows[k]) begin
            @(posedge clk);
            elevated_program_level <= rows[k].fast;
            prog(rows[k].addr, rows[k].data);
            read(rows[k].addr, 8, r);
            check(r, rows[k].data);
        end
        $display("test rows done");
        prog(24'h000010, 8'hc3);
        read(24'h000010, 3, r);
        check(r, 8'hc3);
        $display("test hold done");
        wren();
        start_cmd(sfspi_pkg::op_page_program, 24'h000020);
        send(8'h00);
        m.bit_xfer(1'b0, r[0]);
        m.bit_xfer(1'b0, r[0]);
        m.deselect();
        repeat (8) @(negedge clk);
        check(write_busy, 1'b0);
        // write enable still set: zero data bytes is refused alone
        start_cmd(sfspi_pkg::op_page_program, 24'h000021);
        m.deselect();
        repeat (8) @(negedge clk);
        check(write_busy, 1'b0);
        $display("test refused program done");
        erase(sfspi_pkg::op_sector_erase, 24'h000010);
        read(24'h000010, 8, r);
        check(r, 8'hff);
        // the erase used up the write enable: this program is refused
        start_cmd(sfspi_pkg::op_page_program, 24'h000022);
        send(8'h00);
        m.deselect();
        repeat (8) @(negedge clk);
        check(write_busy, 1'b0);
        $display("test sector erase done");
        results();
    end
endmodule
`default_nettype wire
